// [hw/run_command_source_select.sv]
`timescale 1ns/1ps
// What this block does
// - Setting 1: forward and reverse terminals.
// - Eleven terminal roles; 1 forward, 2 reverse.
// - Setting 1: both on or both off means stop.
// - Delay start after terminal run, 0-100s.
// - Setting 2: run terminal plus direction terminal.
// - Setting 3: commands come from serial link.
// - Setting 0: keypad keys give commands.
module run_command_source_select
    import cmd_src_pkg::*;
#(
    parameter int TICK_COUNT = TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [10:0] multifunction_inputs,
    input wire logic key_forward,
    input wire logic key_reverse,
    input wire logic key_stop,
    input wire logic serial_cmd_valid,
    input wire run_cmd_t serial_cmd,
    output logic run_out,
    output logic reverse_out
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [10:0] pin_meta_q;
    logic [10:0] pin_q;
    logic [2:0] key_meta_q;
    logic [2:0] key_q;
    logic [2:0] key_prev_q;

    always_ff @(posedge aclk) begin
        pin_meta_q <= multifunction_inputs;
        pin_q <= pin_meta_q;
        key_meta_q <= {key_stop, key_reverse, key_forward};
        key_q <= key_meta_q;
        key_prev_q <= key_q;
    end

    // ****************************************************************
    // Settings
    // ****************************************************************
    logic [2:0] source_q;
    logic [13:0] delay_q;
    logic [3:0] fwd_sel_q;
    logic [3:0] rev_sel_q;

    wire aw_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire [31:0] wd = s_axi_wdata;
    wire wr_src = aw_take && s_axi_awaddr == ADDR_SOURCE && s_axi_wstrb[0];
    wire wr_dly = aw_take && s_axi_awaddr == ADDR_DELAY && s_axi_wstrb[1:0] == 2'h3;
    wire wr_fwd = aw_take && s_axi_awaddr == ADDR_FWD_SEL && s_axi_wstrb[0];
    wire wr_rev = aw_take && s_axi_awaddr == ADDR_REV_SEL && s_axi_wstrb[0];
    wire src_ok = wd[2:0] <= SRC_MAX && wd[31:3] == 29'h0;
    wire dly_ok = wd[13:0] <= DELAY_MAX && wd[31:14] == 18'h0;
    wire fwd_ok = wd[31:4] == 28'h0 && wd[3:0] < 4'(NUM_TERMINALS);
    wire aw_known = s_axi_awaddr == ADDR_SOURCE || s_axi_awaddr == ADDR_DELAY
        || s_axi_awaddr == ADDR_FWD_SEL || s_axi_awaddr == ADDR_REV_SEL;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            source_q <= SOURCE_RESET;
            delay_q <= DELAY_RESET;
            fwd_sel_q <= FWD_SEL_RESET;
            rev_sel_q <= REV_SEL_RESET;
        end else begin
            if (wr_src && src_ok) begin
                source_q <= wd[2:0];
            end
            if (wr_dly && dly_ok) begin
                delay_q <= wd[13:0];
            end
            if (wr_fwd && fwd_ok) begin
                fwd_sel_q <= wd[3:0];
            end
            if (wr_rev && fwd_ok) begin
                rev_sel_q <= wd[3:0];
            end
        end
    end

    // ****************************************************************
    // Write response
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= aw_take && !s_axi_awready;
            s_axi_wready <= aw_take && !s_axi_awready;
            if (aw_take && !s_axi_awready) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= aw_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Command interpretation
    // ****************************************************************
    wire fwd_pin = pin_q[fwd_sel_q];
    wire rev_pin = pin_q[rev_sel_q];
    wire term_two = source_q == SRC_TWO_TERMINAL;
    wire term_rpd = source_q == SRC_RUN_PLUS_DIR;
    wire two_run = fwd_pin ^ rev_pin;
    wire two_dir = rev_pin && !fwd_pin;
    wire term_run = term_two ? two_run : fwd_pin;
    wire term_dir = term_two ? two_dir : rev_pin;
    wire term_mode = term_two || term_rpd;
    wire [2:0] key_rise = key_q & ~key_prev_q;

    logic key_run_q;
    logic key_dir_q;
    logic ser_run_q;
    logic ser_dir_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key_run_q <= 1'b0;
            key_dir_q <= 1'b0;
        end else if (key_rise[2]) begin
            key_run_q <= 1'b0;
        end else if (key_rise[0] || key_rise[1]) begin
            key_run_q <= 1'b1;
            key_dir_q <= key_rise[1] && !key_rise[0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ser_run_q <= 1'b0;
            ser_dir_q <= 1'b0;
        end else if (serial_cmd_valid) begin
            ser_run_q <= serial_cmd.run;
            ser_dir_q <= serial_cmd.reverse;
        end
    end

    // ****************************************************************
    // Start delay
    // ****************************************************************
    logic [31:0] tick_cnt_q;
    logic [13:0] wait_q;
    logic armed_q;
    wire tick = tick_cnt_q == 32'(TICK_COUNT - 1);
    wire delay_done = armed_q && wait_q >= delay_q;

    always_ff @(posedge aclk) begin
        if (!aresetn || !term_run || !term_mode) begin
            tick_cnt_q <= 32'h0;
            wait_q <= 14'h0;
            armed_q <= 1'b0;
        end else begin
            armed_q <= 1'b1;
            tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
            if (tick && wait_q < delay_q) begin
                wait_q <= wait_q + 14'h1;
            end
        end
    end

    // ****************************************************************
    // Outputs and read port
    // ****************************************************************
    logic run_d;
    logic dir_d;

    always_comb begin
        case (source_q)
            SRC_KEYPAD: begin
                run_d = key_run_q;
                dir_d = key_dir_q;
            end
            SRC_TWO_TERMINAL, SRC_RUN_PLUS_DIR: begin
                run_d = delay_done && term_run;
                dir_d = term_dir;
            end
            SRC_SERIAL: begin
                run_d = ser_run_q;
                dir_d = ser_dir_q;
            end
            default: begin
                run_d = 1'b0;
                dir_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_out <= 1'b0;
            reverse_out <= 1'b0;
        end else begin
            run_out <= run_d;
            reverse_out <= dir_d;
        end
    end

    logic [31:0] rd_d;
    always_comb begin
        case (s_axi_araddr)
            ADDR_SOURCE: rd_d = {29'h0, source_q};
            ADDR_DELAY: rd_d = {18'h0, delay_q};
            ADDR_FWD_SEL: rd_d = {28'h0, fwd_sel_q};
            ADDR_REV_SEL: rd_d = {28'h0, rev_sel_q};
            ADDR_STATUS: rd_d = {19'h0, pin_q, reverse_out, run_out};
            default: rd_d = 32'h0;
        endcase
    end
    wire ar_known = s_axi_araddr <= ADDR_STATUS && s_axi_araddr[1:0] == 2'h0;
    wire ar_take = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_d;
                s_axi_rresp <= ar_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence both_same_s;
        term_two && (fwd_pin == rev_pin);
    endsequence

    AST_STOP_BOTH: assert property (@(posedge aclk) disable iff (!aresetn)
        both_same_s |=> !run_out)
        else $error("Terminals equal but run asserted.");
    AST_DIR_TWO: assert property (@(posedge aclk) disable iff (!aresetn)
        term_two |=> reverse_out == $past(two_dir))
        else $error("Wrong direction in two-terminal scheme.");
    AST_DIR_RPD: assert property (@(posedge aclk) disable iff (!aresetn)
        term_rpd |=> reverse_out == $past(rev_pin))
        else $error("Direction does not follow direction terminal.");
    AST_ZERO_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
        term_mode && delay_q == 14'h0 && term_run [*2] |=> run_out)
        else $error("Run late with zero delay.");
    AST_RUN_DELAYED: assert property (@(posedge aclk) disable iff (!aresetn)
        term_mode && $rose(run_out) |-> $past(wait_q) >= $past(delay_q))
        else $error("Run started before delay expired.");
    AST_SERIAL: assert property (@(posedge aclk) disable iff (!aresetn)
        source_q == SRC_SERIAL && serial_cmd_valid |=> ##1 run_out == $past(serial_cmd.run, 2))
        else $error("Serial command not applied.");
    AST_KEY_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
        source_q == SRC_KEYPAD && key_rise[2] ##1 source_q == SRC_KEYPAD |=> !run_out)
        else $error("Stop key ignored.");
    AST_ROLE_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
        fwd_sel_q < 4'(NUM_TERMINALS) && rev_sel_q < 4'(NUM_TERMINALS))
        else $error("Terminal role outside the eleven inputs.");

endmodule

// [inc/cmd_src_pkg.sv]
package cmd_src_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ADDR_SOURCE = 8'h00;
    localparam logic [7:0] ADDR_DELAY = 8'h04;
    localparam logic [7:0] ADDR_FWD_SEL = 8'h08;
    localparam logic [7:0] ADDR_REV_SEL = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // ****************************************************************
    // Settings and reset values
    // ****************************************************************
    localparam int NUM_TERMINALS = 11;
    localparam logic [2:0] SRC_KEYPAD = 3'h0;
    localparam logic [2:0] SRC_TWO_TERMINAL = 3'h1;
    localparam logic [2:0] SRC_RUN_PLUS_DIR = 3'h2;
    localparam logic [2:0] SRC_SERIAL = 3'h3;
    localparam logic [2:0] SRC_MAX = 3'h5;
    localparam logic [2:0] SOURCE_RESET = 3'h1;
    localparam logic [5:0] ROLE_FORWARD = 6'h01;
    localparam logic [5:0] ROLE_REVERSE = 6'h02;
    localparam logic [5:0] ROLE_MAX = 6'h33;
    localparam logic [3:0] FWD_SEL_RESET = 4'h0;
    localparam logic [3:0] REV_SEL_RESET = 4'h1;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_US = 10_000;
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam logic [13:0] DELAY_MAX = 14'h2710;
    localparam logic [13:0] DELAY_RESET = 14'h0064;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic run;
        logic reverse;
    } run_cmd_t;

endpackage

// [tb/field_side.sv]
`timescale 1ns/1ps
module field_side
    import cmd_src_pkg::*;
(
    input wire logic aclk,
    output logic [10:0] multifunction_inputs,
    output logic serial_cmd_valid,
    output run_cmd_t serial_cmd
);
    initial begin
        multifunction_inputs = 11'h000;
        serial_cmd_valid = 1'b0;
        serial_cmd = '0;
    end

    // Closes or opens the contacts on the two chosen terminals.
    task automatic set_contacts(input int fi, input int ri, input logic f, input logic r);
        logic [10:0] v;
        v = 11'h000;
        v[fi] = f;
        v[ri] = r;
        @(posedge aclk);
        multifunction_inputs <= v;
    endtask

    // The upper controller sends one command; the payload is not held after it.
    task automatic send_cmd(input run_cmd_t c);
        @(posedge aclk);
        serial_cmd_valid <= 1'b1;
        serial_cmd <= c;
        @(posedge aclk);
        serial_cmd_valid <= 1'b0;
        serial_cmd <= ~c;
    endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench
    import cmd_src_pkg::*;
;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, key_forward, key_reverse, key_stop, serial_cmd_valid;
    logic run_out, reverse_out;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [10:0] multifunction_inputs;
    run_cmd_t serial_cmd;
    int miscompares, samples_checked;

    run_command_source_select #(.TICK_COUNT(4)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .multifunction_inputs(multifunction_inputs), .key_forward(key_forward),
        .key_reverse(key_reverse), .key_stop(key_stop), .serial_cmd_valid(serial_cmd_valid),
        .serial_cmd(serial_cmd), .run_out(run_out), .reverse_out(reverse_out));

    field_side fs (.aclk(aclk), .multifunction_inputs(multifunction_inputs),
        .serial_cmd_valid(serial_cmd_valid), .serial_cmd(serial_cmd));

    // ********
    // Shared tasks
    // ********
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", rdata, exp);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
    endtask

    task automatic wait_run(input logic er, input logic ed, input int lo, input int hi);
        int n;
        n = 0;
        while (!(run_out === er && (er === 1'b0 || reverse_out === ed)) && n < hi) begin
            @(posedge aclk);
            n++;
        end
        chk("run_out", {31'h0, run_out}, {31'h0, er});
        if (er) chk("reverse_out", {31'h0, reverse_out}, {31'h0, ed});
        chk("start_delay", {31'h0, n >= lo}, 32'h1);
    endtask

    task automatic press(input logic [2:0] k);
        @(posedge aclk);
        {key_forward, key_reverse, key_stop} <= k;
        repeat (3) @(posedge aclk);
        {key_forward, key_reverse, key_stop} <= 3'h0;
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_regs;
        rd_chk(ADDR_SOURCE, {29'h0, SOURCE_RESET}, RESP_OKAY);
        rd_chk(ADDR_DELAY, {18'h0, DELAY_RESET}, RESP_OKAY);
        rd_chk(ADDR_FWD_SEL, {28'h0, FWD_SEL_RESET}, RESP_OKAY);
        rd_chk(ADDR_REV_SEL, {28'h0, REV_SEL_RESET}, RESP_OKAY);
        rd_chk(8'h14, 32'h0, RESP_SLVERR);
        wr(8'h14, 32'h0, RESP_SLVERR);
        wr(ADDR_DELAY, 32'h2711, RESP_OKAY);
        rd_chk(ADDR_DELAY, {18'h0, DELAY_RESET}, RESP_OKAY);
        wr(ADDR_DELAY, {18'h0, DELAY_MAX}, RESP_OKAY);
        rd_chk(ADDR_DELAY, {18'h0, DELAY_MAX}, RESP_OKAY);
        wr(ADDR_DELAY, {18'h0, DELAY_RESET}, RESP_OKAY);
        wr(ADDR_FWD_SEL, 32'hb, RESP_OKAY);
        rd_chk(ADDR_FWD_SEL, {28'h0, FWD_SEL_RESET}, RESP_OKAY);
        wr(ADDR_SOURCE, 32'h6, RESP_OKAY);
        rd_chk(ADDR_SOURCE, {29'h0, SOURCE_RESET}, RESP_OKAY);
    endtask

    task automatic t_two;
        fs.set_contacts(0, 1, 1'b1, 1'b0);
        wait_run(1'b1, 1'b0, 396, 440);
        fs.set_contacts(0, 1, 1'b1, 1'b1);
        wait_run(1'b0, 1'b0, 0, 10);
        wr(ADDR_DELAY, 32'h2, RESP_OKAY);
        wr(ADDR_FWD_SEL, 32'ha, RESP_OKAY);
        wr(ADDR_REV_SEL, 32'h3, RESP_OKAY);
        fs.set_contacts(10, 3, 1'b0, 1'b1);
        wait_run(1'b1, 1'b1, 8, 30);
        fs.set_contacts(10, 3, 1'b0, 1'b0);
        wait_run(1'b0, 1'b0, 0, 10);
    endtask

    task automatic t_dir;
        wr(ADDR_SOURCE, {29'h0, SRC_RUN_PLUS_DIR}, RESP_OKAY);
        fs.set_contacts(10, 3, 1'b1, 1'b0);
        wait_run(1'b1, 1'b0, 8, 30);
        fs.set_contacts(10, 3, 1'b1, 1'b1);
        wait_run(1'b1, 1'b1, 0, 10);
        fs.set_contacts(10, 3, 1'b0, 1'b1);
        wait_run(1'b0, 1'b0, 0, 10);
        wr(ADDR_DELAY, 32'h0, RESP_OKAY);
        fs.set_contacts(10, 3, 1'b1, 1'b0);
        wait_run(1'b1, 1'b0, 0, 8);
        fs.set_contacts(10, 3, 1'b0, 1'b0);
        wait_run(1'b0, 1'b0, 0, 10);
    endtask

    task automatic t_keys;
        wr(ADDR_SOURCE, {29'h0, SRC_KEYPAD}, RESP_OKAY);
        fs.set_contacts(10, 3, 1'b1, 1'b0);
        press(3'h4);
        wait_run(1'b1, 1'b0, 0, 20);
        press(3'h2);
        wait_run(1'b1, 1'b1, 0, 20);
        press(3'h1);
        wait_run(1'b0, 1'b0, 0, 20);
    endtask

    task automatic t_serial;
        wr(ADDR_SOURCE, {29'h0, SRC_SERIAL}, RESP_OKAY);
        fs.send_cmd(run_cmd_t'(2'b11));
        wait_run(1'b1, 1'b1, 0, 10);
        rd_chk(ADDR_STATUS, 32'h1003, RESP_OKAY);
        fs.send_cmd(run_cmd_t'(2'b10));
        wait_run(1'b1, 1'b0, 0, 10);
        fs.send_cmd(run_cmd_t'(2'b00));
        wait_run(1'b0, 1'b0, 0, 10);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {key_forward, key_reverse, key_stop} = 3'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0000000000000;
        wstrb = 4'hf;
        miscompares = 0;
        samples_checked = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_two;
        t_dir;
        t_keys;
        t_serial;
        final_report;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        final_report;
    end
endmodule
